// file: hw/pxr_consts.svh
// Functional notes
// - Forwarded read address has low bits zero.
// - Burst crossing 1 MB: fetch, disconnect, refetch.
// - First completion ends at boundary, flag set.
// - Count altered flag only on burst completions.
// - Single word read retired after one phase.
// - Zero byte count means 4 KB, split.
// - Burst reads forwarded as memory read multiple.
// - No free split resource: retry new requests.
// - Boundary check uses byte start address.
// - Second count is original minus delivered, nonnegative.
// - Free only the completed transaction's buffer space.
// - First completion: right data, short count, flag.
// - Each request gets its completions, one resource.
`ifndef PXR_CONSTS_SVH
`define PXR_CONSTS_SVH

`define PXR_SPLIT_SLOTS 3'h4
`define PXR_MB_SPAN 21'h100000
`define PXR_MB_MSB 31
`define PXR_MB_LSB 20
`define PXR_BC_FULL 13'h1000
`define PXR_BC_ZERO 12'h000
`define PXR_CMD_READ_MULTI 4'hC
`define PXR_CMD_READ 4'h6
`define PXR_LOW_ZERO 2'h0

`endif

// file: hw/pxr_pkg.sv
package pxr_pkg;

  typedef logic [31:0] pxr_addr_t;
  typedef logic [12:0] pxr_count_t;

  typedef enum logic [1:0] {
    PXR_ST_IDLE = 2'b00,
    PXR_ST_PCI = 2'b01,
    PXR_ST_CPL = 2'b10
  } pxr_state_t;

endpackage

// file: hw/pxr_read_fwd.sv
`timescale 1ns/10ps
`default_nettype none
`include "pxr_consts.svh"

module pxr_read_fwd (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Split read request from the requester
  input wire logic REQ_VALID_IN,
  input wire pxr_pkg::pxr_addr_t REQ_ADDR_IN,
  input wire logic [11:0] REQ_COUNT_IN,
  input wire logic REQ_BURST_IN,
  input wire logic [4:0] REQ_TAG_IN,
  output logic REQ_SPLIT_OUT,
  output logic REQ_RETRY_OUT,
  // Read on the conventional bus
  output logic PCI_REQ_OUT,
  output pxr_pkg::pxr_addr_t PCI_ADDR_OUT,
  output logic [3:0] PCI_CMD_OUT,
  output pxr_pkg::pxr_count_t PCI_COUNT_OUT,
  input wire logic PCI_DONE_IN,
  // Split completion toward the requester
  output logic CPL_VALID_OUT,
  output logic [4:0] CPL_TAG_OUT,
  output pxr_pkg::pxr_count_t CPL_COUNT_OUT,
  output logic CPL_BCM_OUT,
  output logic CPL_FINAL_OUT,
  input wire logic CPL_READY_IN,
  // Completion buffer release
  output logic BUF_FREE_OUT,
  output pxr_pkg::pxr_count_t BUF_FREE_COUNT_OUT
);
  import pxr_pkg::*;

  pxr_state_t state_reg;
  pxr_addr_t addr_reg;
  pxr_count_t total_reg;
  pxr_count_t first_reg;
  logic burst_reg;
  logic second_reg;
  logic second_pending_reg;

  pxr_count_t req_total;
  logic [20:0] to_boundary;
  logic crosses;
  pxr_count_t req_first;
  pxr_count_t remain;
  pxr_addr_t next_boundary;
  logic cpl_take;

  pxr_res_if res_if ();

  pxr_res_pool u_pool (
    .clk(CLK_IN),
    .reset_n(RESET_N_IN),
    .res(res_if.pool)
  );

  assign req_total = (REQ_COUNT_IN == `PXR_BC_ZERO) ? `PXR_BC_FULL : {1'b0, REQ_COUNT_IN};
  assign to_boundary = `PXR_MB_SPAN - {1'b0, REQ_ADDR_IN[`PXR_MB_LSB-1:0]};
  assign crosses = REQ_BURST_IN && ({8'h00, req_total} > to_boundary);
  assign req_first = crosses ? to_boundary[12:0] : req_total;
  assign remain = (total_reg > first_reg) ? total_reg - first_reg : 13'h0000;
  assign next_boundary = {addr_reg[`PXR_MB_MSB:`PXR_MB_LSB] + 12'h001, 20'h00000};
  assign cpl_take = CPL_VALID_OUT && CPL_READY_IN;

  assign res_if.reserve = (state_reg == PXR_ST_IDLE) && REQ_VALID_IN && res_if.avail;
  assign res_if.release_slot = cpl_take && CPL_FINAL_OUT;

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      REQ_SPLIT_OUT <= 1'b0;
      REQ_RETRY_OUT <= 1'b0;
    end else begin
      REQ_SPLIT_OUT <= res_if.reserve;
      REQ_RETRY_OUT <= REQ_VALID_IN && !res_if.reserve;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= PXR_ST_IDLE;
      addr_reg <= 32'h00000000;
      total_reg <= 13'h0000;
      first_reg <= 13'h0000;
      burst_reg <= 1'b0;
      second_reg <= 1'b0;
      second_pending_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        PXR_ST_IDLE: begin
          if (res_if.reserve) begin
            state_reg <= PXR_ST_PCI;
            addr_reg <= REQ_ADDR_IN;
            total_reg <= req_total;
            first_reg <= req_first;
            burst_reg <= REQ_BURST_IN;
            second_reg <= 1'b0;
            second_pending_reg <= crosses;
          end
        end
        PXR_ST_PCI: begin
          if (PCI_DONE_IN) begin
            state_reg <= PXR_ST_CPL;
          end
        end
        PXR_ST_CPL: begin
          if (cpl_take) begin
            if (second_pending_reg) begin
              state_reg <= PXR_ST_PCI;
              addr_reg <= next_boundary;
              second_reg <= 1'b1;
              second_pending_reg <= 1'b0;
            end else begin
              state_reg <= PXR_ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= PXR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      PCI_REQ_OUT <= 1'b0;
      PCI_ADDR_OUT <= 32'h00000000;
      PCI_CMD_OUT <= `PXR_CMD_READ;
      PCI_COUNT_OUT <= 13'h0000;
    end else if (state_reg == PXR_ST_IDLE && res_if.reserve) begin
      PCI_REQ_OUT <= 1'b1;
      PCI_ADDR_OUT <= {REQ_ADDR_IN[31:2], `PXR_LOW_ZERO};
      PCI_CMD_OUT <= REQ_BURST_IN ? `PXR_CMD_READ_MULTI : `PXR_CMD_READ;
      PCI_COUNT_OUT <= req_first;
    end else if (state_reg == PXR_ST_CPL && cpl_take && second_pending_reg) begin
      PCI_REQ_OUT <= 1'b1;
      PCI_ADDR_OUT <= next_boundary;
      PCI_COUNT_OUT <= remain;
    end else if (PCI_DONE_IN) begin
      PCI_REQ_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      CPL_VALID_OUT <= 1'b0;
      CPL_COUNT_OUT <= 13'h0000;
      CPL_BCM_OUT <= 1'b0;
      CPL_FINAL_OUT <= 1'b0;
    end else if (state_reg == PXR_ST_PCI && PCI_DONE_IN) begin
      CPL_VALID_OUT <= 1'b1;
      CPL_COUNT_OUT <= second_reg ? remain : first_reg;
      CPL_BCM_OUT <= burst_reg && second_pending_reg;
      CPL_FINAL_OUT <= !second_pending_reg;
    end else if (cpl_take) begin
      CPL_VALID_OUT <= 1'b0;
      CPL_FINAL_OUT <= 1'b0;
      CPL_BCM_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      CPL_TAG_OUT <= 5'h00;
    end else if (res_if.reserve) begin
      CPL_TAG_OUT <= REQ_TAG_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      BUF_FREE_OUT <= 1'b0;
      BUF_FREE_COUNT_OUT <= 13'h0000;
    end else begin
      BUF_FREE_OUT <= cpl_take;
      BUF_FREE_COUNT_OUT <= cpl_take ? CPL_COUNT_OUT : 13'h0000;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence single_done_s;
    state_reg == PXR_ST_PCI && !burst_reg && PCI_DONE_IN;
  endsequence

  sequence final_taken_s;
    CPL_VALID_OUT && CPL_FINAL_OUT && CPL_READY_IN;
  endsequence

  chk_addr_low_zero: assert property (PCI_REQ_OUT |-> PCI_ADDR_OUT[1:0] == 2'h0)
    else $error("Forwarded address not word aligned.");
  chk_no_mb_cross: assert property ($rose(PCI_REQ_OUT) && PCI_CMD_OUT == `PXR_CMD_READ_MULTI |->
      (({8'h00, PCI_COUNT_OUT} + {1'b0, PCI_ADDR_OUT[`PXR_MB_LSB-1:0]}) <= `PXR_MB_SPAN + 21'h000003))
    else $error("Burst read runs past a 1 MB boundary.");
  chk_first_short: assert property (CPL_VALID_OUT && !CPL_FINAL_OUT |->
      CPL_BCM_OUT && CPL_COUNT_OUT == first_reg && first_reg < total_reg)
    else $error("First split completion not shortened with flag.");
  chk_flag_burst: assert property (CPL_BCM_OUT |-> burst_reg && !CPL_FINAL_OUT)
    else $error("Count altered flag on a non-burst completion.");
  chk_single_retire: assert property (single_done_s |=> CPL_VALID_OUT && CPL_FINAL_OUT && !CPL_BCM_OUT
      ##0 (!PCI_REQ_OUT throughout (CPL_VALID_OUT [*1])))
    else $error("Single word read not retired after one phase.");
  chk_bc_zero: assert property (state_reg == PXR_ST_IDLE && REQ_VALID_IN && res_if.avail
      && REQ_COUNT_IN == `PXR_BC_ZERO |=> REQ_SPLIT_OUT && total_reg == `PXR_BC_FULL)
    else $error("Zero byte count not taken as 4 KB with split response.");
  chk_burst_cmd: assert property ($rose(PCI_REQ_OUT) |-> (PCI_CMD_OUT == `PXR_CMD_READ_MULTI) == burst_reg)
    else $error("Wrong bus command for forwarded read.");
  chk_retry_full: assert property (REQ_VALID_IN && !(state_reg == PXR_ST_IDLE && res_if.avail) |=>
      REQ_RETRY_OUT && !REQ_SPLIT_OUT)
    else $error("Request not retried with no free resource.");
  chk_second_count: assert property (CPL_VALID_OUT && CPL_FINAL_OUT && second_reg |->
      CPL_COUNT_OUT == total_reg - first_reg && total_reg > first_reg)
    else $error("Second completion count wrong.");
  chk_free_own: assert property (cpl_take |=> BUF_FREE_OUT && BUF_FREE_COUNT_OUT == $past(CPL_COUNT_OUT))
    else $error("Buffer release size differs from completion size.");
  chk_release_final: assert property (res_if.release_slot |-> final_taken_s)
    else $error("Resource released on an intermediate completion.");
  chk_idle_after: assert property (final_taken_s |=> state_reg == PXR_ST_IDLE)
    else $error("Extra completion after the final one.");

endmodule

`default_nettype wire

// file: hw/pxr_res_if.sv
`timescale 1ns/10ps
`default_nettype none

// Split-transaction resource pool handshake between engine and pool.
interface pxr_res_if;
  logic reserve;
  logic release_slot;
  logic avail;

  modport owner (
    output reserve,
    output release_slot,
    input avail
  );

  modport pool (
    input reserve,
    input release_slot,
    output avail
  );
endinterface

`default_nettype wire

// file: hw/pxr_res_pool.sv
`timescale 1ns/10ps
`default_nettype none
`include "pxr_consts.svh"

module pxr_res_pool (
  input wire logic clk,
  input wire logic reset_n,
  pxr_res_if.pool res
);
  import pxr_pkg::*;

  logic [2:0] free_reg;

  assign res.avail = (free_reg != 3'h0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      free_reg <= `PXR_SPLIT_SLOTS;
    end else if (res.reserve && !res.release_slot) begin
      free_reg <= free_reg - 3'h1;
    end else if (res.release_slot && !res.reserve) begin
      free_reg <= free_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_pool_no_overflow: assert property (res.release_slot && !res.reserve |-> free_reg < `PXR_SPLIT_SLOTS)
    else $error("Split resource released more often than reserved.");
  chk_pool_no_underflow: assert property (res.reserve |-> free_reg != 3'h0 || res.release_slot)
    else $error("Split resource reserved while none free.");

endmodule

`default_nettype wire

// file: verification/pxr_far_model.sv
`timescale 1ns/10ps
`default_nettype none

// Bus target and completion sink on the far side of the read engine.
module pxr_far_model (
  input wire logic clk,
  input wire logic pci_req_in,
  output logic pci_done_out,
  output logic cpl_ready_out
);
  initial begin
    pci_done_out = 1'b0;
    cpl_ready_out = 1'b0;
  end

  // Ends each bus read after a random wait, then lets the request drop before watching again.
  always begin
    @(negedge clk iff pci_req_in === 1'b1);
    repeat ($urandom_range(3, 0)) @(negedge clk);
    pci_done_out = 1'b1;
    @(negedge clk);
    pci_done_out = 1'b0;
    @(negedge clk);
  end

  // Stalls completions at random so both prompt and slow acceptance occur.
  always @(negedge clk) begin
    cpl_ready_out = 1'($urandom_range(1, 0));
  end
endmodule

`default_nettype wire

// file: verification/pxr_read_fwd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module pxr_read_fwd_tb_top;
  logic clk, rst_n, rv, rb, rs, rr, pr, done, cv, cb, cf, ry, bf;
  logic [31:0] ra, pa;
  logic [11:0] rc;
  logic [4:0] rt, ct;
  logic [3:0] pc;
  logic [12:0] pn, cn, fn;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  bit q_req[$];
  logic [48:0] q_pci[$];
  logic [19:0] q_cpl[$];
  logic [12:0] q_free[$];
  bit e_req;
  logic [48:0] e_pci;
  logic [19:0] e_cpl;
  logic [12:0] e_free;
  logic pq = 1'b0;

  pxr_read_fwd i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(rv), .REQ_ADDR_IN(ra),
    .REQ_COUNT_IN(rc), .REQ_BURST_IN(rb), .REQ_TAG_IN(rt), .REQ_SPLIT_OUT(rs), .REQ_RETRY_OUT(rr),
    .PCI_REQ_OUT(pr), .PCI_ADDR_OUT(pa), .PCI_CMD_OUT(pc), .PCI_COUNT_OUT(pn), .PCI_DONE_IN(done),
    .CPL_VALID_OUT(cv), .CPL_TAG_OUT(ct), .CPL_COUNT_OUT(cn), .CPL_BCM_OUT(cb), .CPL_FINAL_OUT(cf),
    .CPL_READY_IN(ry), .BUF_FREE_OUT(bf), .BUF_FREE_COUNT_OUT(fn));

  pxr_far_model i_far (.clk(clk), .pci_req_in(pr), .pci_done_out(done), .cpl_ready_out(ry));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Notes the owed answers, offers the request, and optionally a second one while busy.
  task automatic send(input logic [31:0] a, input logic [11:0] c, input logic b, input logic [4:0] t,
                      input bit busy);
    logic [12:0] tot;
    logic [20:0] rem;
    tot = (c == 12'h000) ? 13'h1000 : {1'b0, c};
    rem = 21'h100000 - {1'b0, a[19:0]};
    q_req.push_back(1'b1);
    if (b && rem < {8'h00, tot}) begin
      q_pci.push_back({a[31:2], 2'h0, 4'hC, rem[12:0]});
      q_pci.push_back({a[31:20] + 12'h001, 20'h00000, 4'hC, tot - rem[12:0]});
      q_cpl.push_back({t, rem[12:0], 1'b1, 1'b0});
      q_cpl.push_back({t, tot - rem[12:0], 1'b0, 1'b1});
      q_free.push_back(rem[12:0]);
      q_free.push_back(tot - rem[12:0]);
    end else begin
      q_pci.push_back({a[31:2], 2'h0, b ? 4'hC : 4'h6, tot});
      q_cpl.push_back({t, tot, 1'b0, 1'b1});
      q_free.push_back(tot);
    end
    {rv, ra, rc, rb, rt} = {1'b1, a, c, b, t};
    @(negedge clk);
    rv = 1'b0;
    if (busy) begin
      @(negedge clk);
      q_req.push_back(1'b0);
      {rv, ra} = {1'b1, ~a};
      @(negedge clk);
      rv = 1'b0;
    end
    for (int i = 0; i < 300 && (q_pci.size() + q_cpl.size() + q_free.size()) > 0; i++) @(negedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (rs || rr) begin
      e_req = q_req.pop_front();
      `CHK({rs, rr}, e_req ? 2'b10 : 2'b01) // accept or retry
    end
    if (pr && !pq) begin
      e_pci = q_pci.pop_front();
      `CHK({pa, pc, pn}, e_pci)
    end
    pq = pr;
    if (cv && ry) begin
      e_cpl = q_cpl.pop_front();
      `CHK({ct, cn, cb, cf}, e_cpl)
    end
    if (bf) begin
      e_free = q_free.pop_front();
      `CHK(fn, e_free) // freed count
    end
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    logic [31:0] a;
    {rst_n, rv, ra, rc, rb, rt} = '0;
    void'($urandom(32'h7c5a));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    send(32'h000FFFF5, 12'h010, 1'b1, 5'h01, 1'b1);
    send(32'h000FFFF7, 12'h00C, 1'b1, 5'h02, 1'b0);
    send(32'h123FFFFE, 12'h000, 1'b1, 5'h03, 1'b0);
    send(32'h00200000, 12'h000, 1'b1, 5'h04, 1'b1);
    send(32'h000FFFFF, 12'h001, 1'b0, 5'h05, 1'b0);
    send(32'h000FFFFC, 12'h004, 1'b0, 5'h06, 1'b0);
    send(32'h00300000, 12'h004, 1'b1, 5'h07, 1'b0);
    for (int i = 0; i < 150; i++) begin
      a = $urandom;
      if (i % 2 == 0) a[19:0] = 20'hFFFFF - 20'($urandom_range(15, 0));
      if (i % 3 == 0) begin
        send(a, 12'($urandom_range(3 - a[1:0], 0) + 1), 1'b0, 5'($urandom), i % 5 == 0);
      end else begin
        send(a, 12'($urandom), 1'b1, 5'($urandom), i % 5 == 0);
      end
    end
    `CHK(q_req.size() + q_pci.size() + q_cpl.size() + q_free.size(), 0) // nothing owed
    test_done();
  end
endmodule

`default_nettype wire
